/* File: hw/slem_pkg.sv */
package slem_pkg;

   // register port geometry
   localparam int unsigned REG_ADDR_W = 32'hc;
   localparam int unsigned REG_DATA_W = 32'h8;

   // register byte addresses
   localparam logic [11:0] ADDR_DENSITY_CONTROL  = 12'h45a;
   localparam logic [11:0] ADDR_RESERVED_A       = 12'h45b;
   localparam logic [11:0] ADDR_RESERVED_B       = 12'h45c;
   localparam logic [11:0] ADDR_LANE0_CHECKSUM   = 12'h45d;
   localparam logic [11:0] ADDR_ERROR_MONITOR    = 12'h46b;
   localparam logic [11:0] ADDR_LANE_ALIGNMENT   = 12'h46c;
   localparam logic [11:0] ADDR_DISPARITY_ERROR  = 12'h46d;
   localparam logic [11:0] ADDR_INVALID_SYMBOL   = 12'h46e;

   // field positions of the density / control word register
   localparam int unsigned HD_BIT                = 32'h7;
   localparam int unsigned CF_MSB                = 32'h4;

   // field positions of the error monitor select register
   localparam int unsigned SEL_LANE_MSB          = 32'h6;
   localparam int unsigned SEL_LANE_LSB          = 32'h4;
   localparam int unsigned SEL_TYPE_MSB          = 32'h1;

   // field positions of the error control registers
   localparam int unsigned CTRL_IRQ_CLEAR_BIT    = 32'h7;
   localparam int unsigned CTRL_CNT_DISABLE_BIT  = 32'h6;
   localparam int unsigned CTRL_CNT_CLEAR_BIT    = 32'h5;
   localparam int unsigned CTRL_LANE_MSB         = 32'h2;

   // reset values
   localparam logic        HD_RST                = 1'h1;
   localparam logic [4:0]  CF_RST                = 5'h00;
   localparam logic [7:0]  RESERVED_RST          = 8'h00;
   localparam logic [7:0]  CHECKSUM_RST          = 8'h45;
   localparam logic [7:0]  ALIGN_MASK_RST        = 8'h0f;
   localparam logic [7:0]  READ_ZERO             = 8'h00;

   // legal octets-per-frame settings, stored minus one
   localparam logic [7:0]  F_ONE_M1              = 8'h00;
   localparam logic [7:0]  F_TWO_M1              = 8'h01;
   localparam logic [7:0]  F_FOUR_M1             = 8'h03;

   // error counter kinds on the readback select
   typedef enum logic [1:0] {
      CNT_DISPARITY  = 2'h0,
      CNT_INVALID    = 2'h1,
      CNT_UNEXPECTED = 2'h2
   } slem_cnt_kind_type;

endpackage : slem_pkg

/* File: hw/slem_err_counter.sv */
`timescale 1ns/1ps

module slem_err_counter
   import slem_pkg::*;
#(
   parameter int unsigned CNT_W = 8
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // event and commands
   input  wire logic             err_event,
   input  wire logic             count_clear,
   input  wire logic             count_disable,
   input  wire logic [CNT_W-1:0] threshold,
   // state
   output logic      [CNT_W-1:0] count,
   output logic                  threshold_hit
);

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             hit;
   } slem_counter_state_type;

   localparam logic [CNT_W-1:0] CNT_MAX  = '1;
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   slem_counter_state_type s;
   slem_counter_state_type next_s;

   // saturating count; hit marks the step onto the threshold
   always_comb begin
      next_s     = s;
      next_s.hit = 1'b0;
      if (count_clear) begin
         next_s.count = CNT_ZERO;
      end else if (err_event && !count_disable && (s.count != CNT_MAX)) begin
         next_s.count = s.count + 1'b1;
         // a zero threshold is never hit: the count cannot wrap
         next_s.hit   = (next_s.count == threshold);
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s.count <= CNT_ZERO;
         s.hit   <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign count         = s.count;
   assign threshold_hit = s.hit;

endmodule : slem_err_counter

/* File: hw/slem_regs.sv */
`timescale 1ns/1ps
// Functional notes
// RQ1 - density bit set only when F is one
// RQ2 - control words per frame kept zero
// RQ3 - lane 0 checksum, reset 0x45, mode-chosen method
// RQ4 - monitor read returns selected lane counter
// RQ5 - type 00 disparity, 01 invalid, 10 control
// RQ6 - deskew mask per lane, resets to 0xF
// RQ7 - disparity flag set on threshold reach
// RQ8 - control bit 7 clears disparity interrupt
// RQ9 - control bit 6 disables disparity counter
// RQ10 - control bit 5 clears disparity counter
// RQ11 - bits 2:0 address the commanded lane
// RQ12 - invalid-symbol flag set on threshold reach
// RQ13 - control bit 7 clears invalid-symbol interrupt
// RQ14 - two reserved fields, writable, reset zero
// RQ15 - F stored minus one; 1,2,4 valid
// RQ16 - shared address: read flags, write commands
// RQ17 - reserved bits read zero, writes ignored

module slem_regs
   import slem_pkg::*;
#(
   parameter int unsigned LANES = 8,
   parameter int unsigned CNT_W = 8
) (
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   // register port from the serial port engine
   input  wire logic [REG_ADDR_W-1:0] reg_addr,
   input  wire logic                  reg_wr_en,
   input  wire logic [REG_DATA_W-1:0] reg_wr_data,
   input  wire logic                  reg_rd_en,
   output logic      [REG_DATA_W-1:0] reg_rd_data,
   output logic                       reg_rd_valid,
   // per-lane error events
   input  wire logic [LANES-1:0]      disparity_event,
   input  wire logic [LANES-1:0]      invalid_symbol_event,
   input  wire logic [LANES-1:0]      unexpected_k_event,
   input  wire logic [CNT_W-1:0]      error_threshold,
   // checksum sources from the link configuration
   input  wire logic                  checksum_mode,
   input  wire logic                  checksum_recalc,
   input  wire logic [7:0]            config_field_sum,
   input  wire logic [7:0]            config_octet_sum,
   input  wire logic [7:0]            frame_octets_m1,
   // configuration towards the link receiver
   output logic                       density_high,
   output logic      [4:0]            control_words,
   output logic      [7:0]            lane0_checksum,
   output logic      [7:0]            alignment_lane_mask,
   output logic                       config_error,
   // lane error status
   output logic      [LANES-1:0]      disparity_flag,
   output logic      [LANES-1:0]      invalid_symbol_flag
);

   // refuse sizes the 8-bit map and 3-bit lane fields cannot carry
   generate
      if ((LANES < 1) || (LANES > 8) || (CNT_W < 1) || (CNT_W > 8)) begin : g_bad_param
         $error("slem_regs: LANES and CNT_W must each lie in 1..8");
      end
   endgenerate

   typedef struct packed {
      logic                  hd;
      logic [4:0]            cf;
      logic [7:0]            res_a;
      logic [7:0]            res_b;
      logic [7:0]            checksum;
      logic [2:0]            sel_lane;
      logic [1:0]            sel_type;
      logic [7:0]            align_mask;
      logic [LANES-1:0]      disp_flag;
      logic [LANES-1:0]      inv_flag;
      logic [LANES-1:0]      disp_off;
      logic [LANES-1:0]      inv_off;
      logic [REG_DATA_W-1:0] rd_data;
      logic                  rd_valid;
      logic                  cfg_bad;
   } slem_state_type;

   slem_state_type s;
   slem_state_type next_s;

   // write strobes of the two shared status / command addresses
   logic disp_ctrl_wr;
   logic inv_ctrl_wr;

   // per-lane commands decoded from the control writes
   logic [LANES-1:0] disparity_irq_clear;
   logic [LANES-1:0] disparity_counter_disable;
   logic [LANES-1:0] disparity_counter_clear;
   logic [LANES-1:0] invalid_symbol_irq_clear;
   logic [LANES-1:0] invalid_symbol_counter_disable;
   logic [LANES-1:0] invalid_symbol_counter_clear;

   // counter state per lane and kind
   logic [CNT_W-1:0] disparity_counter      [LANES];
   logic [CNT_W-1:0] invalid_symbol_counter [LANES];
   logic [CNT_W-1:0] unexpected_k_counter   [LANES];
   logic [LANES-1:0] disparity_hit;
   logic [LANES-1:0] invalid_symbol_hit;

   // read path and checksum sources
   logic [CNT_W-1:0] counter_pick;
   logic [7:0]       counter_value;
   logic [7:0]       read_value;
   logic [7:0]       density_octet;
   logic [7:0]       field_total;
   logic [7:0]       octet_total;
   logic             f_legal;
   logic             f_is_one;

   assign disp_ctrl_wr = reg_wr_en && (reg_addr == ADDR_DISPARITY_ERROR);
   assign inv_ctrl_wr  = reg_wr_en && (reg_addr == ADDR_INVALID_SYMBOL);

   // command decoder and counters per lane
   genvar lane;
   generate
      for (lane = 0; lane < LANES; lane++) begin : g_lane
         logic lane_hit;

         // the lane field of the same write picks the lane
         assign lane_hit = (reg_wr_data[CTRL_LANE_MSB:0] == 3'(lane)); // RQ11

         assign disparity_irq_clear[lane] =
            disp_ctrl_wr && reg_wr_data[CTRL_IRQ_CLEAR_BIT] && lane_hit; // RQ8
         assign disparity_counter_disable[lane] =
            disp_ctrl_wr && reg_wr_data[CTRL_CNT_DISABLE_BIT] && lane_hit; // RQ9
         assign disparity_counter_clear[lane] =
            disp_ctrl_wr && reg_wr_data[CTRL_CNT_CLEAR_BIT] && lane_hit; // RQ10
         assign invalid_symbol_irq_clear[lane] =
            inv_ctrl_wr && reg_wr_data[CTRL_IRQ_CLEAR_BIT] && lane_hit; // RQ13
         assign invalid_symbol_counter_disable[lane] =
            inv_ctrl_wr && reg_wr_data[CTRL_CNT_DISABLE_BIT] && lane_hit;
         assign invalid_symbol_counter_clear[lane] =
            inv_ctrl_wr && reg_wr_data[CTRL_CNT_CLEAR_BIT] && lane_hit;

         // bad running disparity
         slem_err_counter #(
            .CNT_W         (CNT_W)
         ) u_disparity (
            .sys_clk       (sys_clk),
            .rst           (rst),
            .err_event     (disparity_event[lane]),
            .count_clear   (disparity_counter_clear[lane]),
            .count_disable (s.disp_off[lane]),
            .threshold     (error_threshold),
            .count         (disparity_counter[lane]),
            .threshold_hit (disparity_hit[lane])
         );

         // symbols missing from the decode table
         slem_err_counter #(
            .CNT_W         (CNT_W)
         ) u_invalid (
            .sys_clk       (sys_clk),
            .rst           (rst),
            .err_event     (invalid_symbol_event[lane]),
            .count_clear   (invalid_symbol_counter_clear[lane]),
            .count_disable (s.inv_off[lane]),
            .threshold     (error_threshold),
            .count         (invalid_symbol_counter[lane]),
            .threshold_hit (invalid_symbol_hit[lane])
         );

         // unexpected control characters; no clear or disable command reaches them
         slem_err_counter #(
            .CNT_W         (CNT_W)
         ) u_unexpected (
            .sys_clk       (sys_clk),
            .rst           (rst),
            .err_event     (unexpected_k_event[lane]),
            .count_clear   (1'b0),
            .count_disable (1'b0),
            .threshold     (error_threshold),
            .count         (unexpected_k_counter[lane]),
            .threshold_hit ()
         );
      end
   endgenerate

   // counter chosen by the stored lane and kind selects
   always_comb begin
      counter_pick  = '0;
      counter_value = READ_ZERO;
      if (int'(s.sel_lane) < LANES) begin // RQ4
         unique case (s.sel_type) // RQ5
            CNT_DISPARITY:  counter_pick = disparity_counter[s.sel_lane];
            CNT_INVALID:    counter_pick = invalid_symbol_counter[s.sel_lane];
            CNT_UNEXPECTED: counter_pick = unexpected_k_counter[s.sel_lane];
            default:        counter_pick = '0;
         endcase
      end
      // narrow counters read zero-extended
      counter_value[CNT_W-1:0] = counter_pick;
   end

   // octet image of the density register, reserved bits forced low
   always_comb begin
      density_octet                = READ_ZERO; // RQ17
      density_octet[HD_BIT]        = s.hd;
      density_octet[CF_MSB:0]      = s.cf;
   end

   // read mux; shared addresses show status, not commands
   always_comb begin
      read_value = READ_ZERO;
      unique case (reg_addr)
         ADDR_DENSITY_CONTROL: read_value = density_octet;
         ADDR_RESERVED_A:      read_value = s.res_a;
         ADDR_RESERVED_B:      read_value = s.res_b;
         ADDR_LANE0_CHECKSUM:  read_value = s.checksum;
         ADDR_ERROR_MONITOR:   read_value = counter_value; // RQ4
         ADDR_LANE_ALIGNMENT:  read_value = s.align_mask;
         ADDR_DISPARITY_ERROR: read_value[LANES-1:0] = s.disp_flag; // RQ16
         ADDR_INVALID_SYMBOL:  read_value[LANES-1:0] = s.inv_flag; // RQ16
         default:              read_value = READ_ZERO;
      endcase
   end

   // both checksum methods, modulo 256 over the configuration
   always_comb begin
      field_total = config_field_sum
                  + {7'h00, s.hd}
                  + {3'h0, s.cf}
                  + s.res_a
                  + s.res_b;
      octet_total = config_octet_sum
                  + density_octet
                  + s.res_a
                  + s.res_b;
   end

   // software duties on F, density and control words
   always_comb begin
      f_is_one = (frame_octets_m1 == F_ONE_M1);
      f_legal  = f_is_one
              || (frame_octets_m1 == F_TWO_M1)
              || (frame_octets_m1 == F_FOUR_M1); // RQ15
   end

   // next state of the whole bank
   always_comb begin
      next_s          = s;
      next_s.rd_valid = 1'b0;

      // storage writes; reserved bits are dropped
      if (reg_wr_en) begin
         unique case (reg_addr)
            ADDR_DENSITY_CONTROL: begin
               next_s.hd = reg_wr_data[HD_BIT];
               next_s.cf = reg_wr_data[CF_MSB:0]; // RQ17
            end
            ADDR_RESERVED_A: begin
               next_s.res_a = reg_wr_data; // RQ14
            end
            ADDR_RESERVED_B: begin
               next_s.res_b = reg_wr_data; // RQ14
            end
            ADDR_LANE0_CHECKSUM: begin
               next_s.checksum = reg_wr_data;
            end
            ADDR_ERROR_MONITOR: begin
               next_s.sel_lane = reg_wr_data[SEL_LANE_MSB:SEL_LANE_LSB]; // RQ4
               next_s.sel_type = reg_wr_data[SEL_TYPE_MSB:0]; // RQ4
            end
            ADDR_LANE_ALIGNMENT: begin
               next_s.align_mask = reg_wr_data; // RQ6
            end
            default: begin
            end
         endcase
      end

      // a recalculation beats a same-cycle software write
      if (checksum_recalc) begin
         next_s.checksum = checksum_mode ? octet_total : field_total; // RQ3
      end

      // sticky flags; a hit beats a same-cycle clear
      next_s.disp_flag = (s.disp_flag & ~disparity_irq_clear) | disparity_hit; // RQ7
      next_s.inv_flag  = (s.inv_flag & ~invalid_symbol_irq_clear)
                       | invalid_symbol_hit; // RQ12

      // disable is sticky until reset; there is no enable
      next_s.disp_off = s.disp_off | disparity_counter_disable; // RQ9
      next_s.inv_off  = s.inv_off | invalid_symbol_counter_disable;

      // flag a configuration the receiver cannot run
      next_s.cfg_bad = !f_legal // RQ15
                    || (s.hd != f_is_one) // RQ1
                    || (s.cf != CF_RST); // RQ2

      // read data taken at the request edge, held to the next read
      if (reg_rd_en) begin
         next_s.rd_data  = read_value;
         next_s.rd_valid = 1'b1;
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s.hd         <= HD_RST;
         s.cf         <= CF_RST;
         s.res_a      <= RESERVED_RST; // RQ14
         s.res_b      <= RESERVED_RST; // RQ14
         s.checksum   <= CHECKSUM_RST; // RQ3
         s.sel_lane   <= '0;
         s.sel_type   <= CNT_DISPARITY;
         s.align_mask <= ALIGN_MASK_RST; // RQ6
         s.disp_flag  <= '0;
         s.inv_flag   <= '0;
         s.disp_off   <= '0;
         s.inv_off    <= '0;
         s.rd_data    <= READ_ZERO;
         s.rd_valid   <= 1'b0;
         s.cfg_bad    <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign reg_rd_data         = s.rd_data;
   assign reg_rd_valid        = s.rd_valid;
   assign density_high        = s.hd;
   assign control_words       = s.cf;
   assign lane0_checksum      = s.checksum;
   assign alignment_lane_mask = s.align_mask; // RQ6
   assign config_error        = s.cfg_bad;
   assign disparity_flag      = s.disp_flag;
   assign invalid_symbol_flag = s.inv_flag;

endmodule : slem_regs

/* File: verif/slem_regs_asserts.sv */
`timescale 1ns/1ps
module slem_regs_asserts
   import slem_pkg::*;
#(
   parameter int unsigned LANES = 8,
   parameter int unsigned CNT_W = 8
) (
   // clock, reset and register port
   input logic                  sys_clk,
   input logic                  rst,
   input logic [REG_ADDR_W-1:0] reg_addr,
   input logic                  reg_wr_en,
   input logic [REG_DATA_W-1:0] reg_wr_data,
   input logic                  reg_rd_en,
   input logic [REG_DATA_W-1:0] reg_rd_data,
   input logic                  reg_rd_valid,
   // lane events and status
   input logic [LANES-1:0]      disparity_event,
   input logic [LANES-1:0]      invalid_symbol_event,
   input logic                  density_high,
   input logic [4:0]            control_words,
   input logic [7:0]            alignment_lane_mask,
   input logic [LANES-1:0]      disparity_flag,
   input logic [LANES-1:0]      invalid_symbol_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // lane 0 clears, judged with no hit in flight
   sequence s_disp_quiet; (!disparity_event[0]) [*3]; endsequence
   sequence s_nit_quiet; (!invalid_symbol_event[0]) [*3]; endsequence
   sequence s_disp_clr;
      reg_wr_en && reg_addr == ADDR_DISPARITY_ERROR && reg_wr_data[7] && !reg_wr_data[2:0];
   endsequence
   sequence s_nit_clr;
      reg_wr_en && reg_addr == ADDR_INVALID_SYMBOL && reg_wr_data[7] && !reg_wr_data[2:0];
   endsequence

   property p_rd_answer; 1'b1 |=> reg_rd_valid == $past(reg_rd_en); endproperty
   property p_mask_wr;
      reg_wr_en && reg_addr == ADDR_LANE_ALIGNMENT |=> alignment_lane_mask == $past(reg_wr_data);
   endproperty
   property p_hd_wr;
      reg_wr_en && reg_addr == ADDR_DENSITY_CONTROL
         |=> {density_high, 2'h0, control_words} == ($past(reg_wr_data) & 8'h9f);
   endproperty
   property p_rsv_rd;
      reg_rd_en && reg_addr == ADDR_DENSITY_CONTROL |=> reg_rd_data[6:5] == 2'h0;
   endproperty
   property p_flags_rd;
      reg_rd_en && reg_addr == ADDR_DISPARITY_ERROR |=> reg_rd_data == 8'($past(disparity_flag));
   endproperty
   property p_disp_rise;
      $rose(disparity_flag[0]) |-> $past(disparity_event[0], 2) || $past(disparity_event[0], 3);
   endproperty
   property p_nit_rise;
      $rose(invalid_symbol_flag[0])
         |-> $past(invalid_symbol_event[0], 2) || $past(invalid_symbol_event[0], 3);
   endproperty
   property p_disp_clr; s_disp_quiet ##0 s_disp_clr |=> !disparity_flag[0]; endproperty
   property p_nit_clr; s_nit_quiet ##0 s_nit_clr |=> !invalid_symbol_flag[0]; endproperty
   // lane 0 disparity flag drops only on a clear write
   property p_disp_hold;
      $fell(disparity_flag[0])
         |-> $past(reg_wr_en && reg_addr == ADDR_DISPARITY_ERROR && reg_wr_data[7]);
   endproperty

   a_rd_answer: assert property (p_rd_answer)
      else $error("late read valid");
   a_mask_wr: assert property (p_mask_wr)
      else $error("mask write lost");
   a_hd_wr: assert property (p_hd_wr)
      else $error("density write lost");
   a_rsv_rd: assert property (p_rsv_rd)
      else $error("reserved bits not zero");
   a_flags_rd: assert property (p_flags_rd)
      else $error("flag read wrong");
   a_disp_rise: assert property (p_disp_rise)
      else $error("stray disparity flag");
   a_nit_rise: assert property (p_nit_rise)
      else $error("stray invalid flag");
   a_disp_clr: assert property (p_disp_clr)
      else $error("disparity flag not cleared");
   a_nit_clr: assert property (p_nit_clr)
      else $error("invalid flag not cleared");
   a_disp_hold: assert property (p_disp_hold)
      else $error("disparity flag dropped");
endmodule : slem_regs_asserts

bind slem_regs slem_regs_asserts #(.LANES(LANES), .CNT_W(CNT_W)) u_asserts (
   .sys_clk, .rst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
   .reg_rd_valid, .disparity_event, .invalid_symbol_event, .density_high, .control_words,
   .alignment_lane_mask, .disparity_flag, .invalid_symbol_flag
);

/* File: verif/slem_link_tx_model.sv */
`timescale 1ns/1ps
module slem_link_tx_model #(
   parameter int unsigned LANES = 8
) (
   // receiver clock
   input  wire logic             sys_clk,
   // one high cycle per bad symbol
   output logic      [LANES-1:0] disparity_event,
   output logic      [LANES-1:0] invalid_symbol_event,
   output logic      [LANES-1:0] unexpected_k_event
);
   // clean link at start
   initial {disparity_event, invalid_symbol_event, unexpected_k_event} = '0;

   // error burst; gap idle cycles follow each bad symbol
   task automatic send_errors(input int kind, input int lane, input int n, input int gap);
      repeat (n) begin
         @(negedge sys_clk);
         disparity_event[lane] = (kind == 0);
         invalid_symbol_event[lane] = (kind == 1);
         unexpected_k_event[lane] = (kind == 2);
         repeat (gap) begin
            @(negedge sys_clk);
            {disparity_event, invalid_symbol_event, unexpected_k_event} = '0;
         end
      end
      @(negedge sys_clk);
      {disparity_event, invalid_symbol_event, unexpected_k_event} = '0;
   endtask : send_errors
endmodule : slem_link_tx_model

/* File: verif/serial_link_lane_error_monitor_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   checks++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected t=%0t got %h exp %h", $time, (got), (exp)); \
   end \
end

module serial_link_lane_error_monitor_tb
   import slem_pkg::*;
;
   // stimulus, driven on falling edges
   logic                  sys_clk          = 1'b0;
   logic                  rst              = 1'b1;
   logic [REG_ADDR_W-1:0] reg_addr         = '0;
   logic                  reg_wr_en        = 1'b0;
   logic [REG_DATA_W-1:0] reg_wr_data      = '0;
   logic                  reg_rd_en        = 1'b0;
   logic [7:0]            error_threshold  = 8'h03;
   logic                  checksum_mode    = 1'b0;
   logic                  checksum_recalc  = 1'b0;
   logic [7:0]            config_field_sum = '0;
   logic [7:0]            config_octet_sum = '0;
   logic [7:0]            frame_octets_m1  = F_ONE_M1;
   // outputs and partner events
   logic [7:0] reg_rd_data, lane0_checksum, alignment_lane_mask, disparity_flag;
   logic [7:0] invalid_symbol_flag, disparity_event, invalid_symbol_event, unexpected_k_event;
   logic       reg_rd_valid, density_high, config_error;
   logic [4:0] control_words;
   // reference model and corners
   logic [7:0] ecnt [3][8] = '{default: '0};
   logic       edis [3][8] = '{default: '0};
   logic [7:0] eflag [2] = '{default: '0};
   logic [7:0] ra, rb, cmd;
   int         ck [3][5] = '{'{0, 5, 3, 1, 'h20}, '{1, 0, 4, 1, 'h80}, '{0, 0, 3, 0, 'h80}};
   int         err_count = 0, checks = 0, seed = 56513, cycles = 0, k, ln, n, kc;

   always #10 sys_clk = ~sys_clk;

   // hang guard, well above the run length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   slem_regs #(.LANES(8), .CNT_W(8)) u_dut (
      .sys_clk, .rst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
      .reg_rd_valid, .disparity_event, .invalid_symbol_event, .unexpected_k_event,
      .error_threshold, .checksum_mode, .checksum_recalc, .config_field_sum,
      .config_octet_sum, .frame_octets_m1, .density_high, .control_words, .lane0_checksum,
      .alignment_lane_mask, .config_error, .disparity_flag, .invalid_symbol_flag
   );
   slem_link_tx_model #(.LANES(8)) u_tx (
      .sys_clk, .disparity_event, .invalid_symbol_event, .unexpected_k_event
   );

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge sys_clk);
      reg_rd_en = 1'b0;
      `CHK(reg_rd_valid, 1'b1)
      `CHK(reg_rd_data, e)
   endtask : rdchk

   // config flag settles two cycles later
   task automatic cfgchk(input logic [7:0] d, input logic [7:0] f, input logic e);
      wr(ADDR_DENSITY_CONTROL, d);
      frame_octets_m1 = f;
      repeat (3) @(negedge sys_clk);
      `CHK(config_error, e)
   endtask : cfgchk

   function automatic logic [7:0] csum_exp(input logic md, input logic [7:0] hc);
      if (md)
         return config_octet_sum + hc + ra + rb;
      return config_field_sum + {7'h00, hc[7]} + {3'h0, hc[4:0]} + ra + rb;
   endfunction : csum_exp

   // saturating counts; a flag sets on the step onto threshold
   function automatic void model_errs(input int kd, input int l, input int cnt);
      for (int i = 0; i < cnt; i++) begin
         if (!edis[kd][l] && ecnt[kd][l] != 8'hff) begin
            ecnt[kd][l]++;
            if (kd < 2 && ecnt[kd][l] == error_threshold)
               eflag[kd][l] = 1'b1;
         end
      end
   endfunction : model_errs

   function automatic void model_cmd(input int c, input logic [7:0] d);
      if (d[7])
         eflag[c][d[2:0]] = 1'b0;
      if (d[6])
         edis[c][d[2:0]] = 1'b1;
      if (d[5])
         ecnt[c][d[2:0]] = '0;
   endfunction : model_cmd

   task automatic tally_and_finish();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   // main sequence
   initial begin
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      rdchk(ADDR_DENSITY_CONTROL, 8'h80);
      rdchk(ADDR_RESERVED_A, 8'h00);
      rdchk(ADDR_RESERVED_B, 8'h00);
      rdchk(ADDR_LANE0_CHECKSUM, 8'h45);
      rdchk(ADDR_LANE_ALIGNMENT, 8'h0f);
      rdchk(ADDR_ERROR_MONITOR, 8'h00);
      rdchk(12'h000, 8'h00);
      ra = $random(seed);
      rb = $random(seed);
      cmd = $random(seed);
      wr(ADDR_RESERVED_A, ra);
      wr(ADDR_RESERVED_B, rb);
      wr(ADDR_LANE_ALIGNMENT, cmd);
      wr(ADDR_DENSITY_CONTROL, 8'hff);
      rdchk(ADDR_RESERVED_A, ra);
      rdchk(ADDR_RESERVED_B, rb);
      rdchk(ADDR_LANE_ALIGNMENT, cmd);
      rdchk(ADDR_DENSITY_CONTROL, 8'h9f);
      `CHK(alignment_lane_mask, cmd)
      // recompute in both modes, HD and CF set
      for (int md = 0; md < 2; md++) begin
         config_field_sum = $random(seed);
         config_octet_sum = $random(seed);
         checksum_mode = md[0];
         checksum_recalc = 1'b1;
         @(negedge sys_clk);
         checksum_recalc = 1'b0;
         rdchk(ADDR_LANE0_CHECKSUM, csum_exp(md[0], 8'h9f));
      end
      wr(ADDR_LANE0_CHECKSUM, rb);
      rdchk(ADDR_LANE0_CHECKSUM, rb);
      `CHK(lane0_checksum, rb)
      cfgchk(8'h80, F_ONE_M1, 1'b0);
      cfgchk(8'h80, F_TWO_M1, 1'b1);
      cfgchk(8'h00, F_FOUR_M1, 1'b0);
      cfgchk(8'h01, F_FOUR_M1, 1'b1);
      cfgchk(8'h00, 8'h02, 1'b1);
      // lane 5 disparity counter frozen first
      wr(ADDR_DISPARITY_ERROR, 8'h45);
      model_cmd(0, 8'h45);
      for (int it = 0; it < 16; it++) begin
         k = {$random(seed)} % 3;
         ln = {$random(seed)} % 8;
         n = {$random(seed)} % 5;
         kc = $random(seed) & 1;
         cmd = $random(seed);
         if (it < 3) begin
            k = ck[it][0];
            ln = ck[it][1];
            n = ck[it][2];
            kc = ck[it][3];
            cmd = 8'(ck[it][4]);
         end
         u_tx.send_errors(k, ln, n, it % 3);
         model_errs(k, ln, n);
         repeat (4) @(negedge sys_clk);
         rdchk(ADDR_DISPARITY_ERROR, eflag[0]);
         rdchk(ADDR_INVALID_SYMBOL, eflag[1]);
         wr(ADDR_ERROR_MONITOR, {1'b0, ln[2:0], 2'b00, k[1:0]});
         rdchk(ADDR_ERROR_MONITOR, ecnt[k][ln]);
         wr(kc[0] ? ADDR_INVALID_SYMBOL : ADDR_DISPARITY_ERROR, cmd);
         model_cmd(kc, cmd);
      end
      rdchk(ADDR_DISPARITY_ERROR, eflag[0]);
      rdchk(ADDR_INVALID_SYMBOL, eflag[1]);
      wr(ADDR_ERROR_MONITOR, 8'h73);
      rdchk(ADDR_ERROR_MONITOR, 8'h00);
      tally_and_finish();
   end
endmodule : serial_link_lane_error_monitor_tb
